// >>> core/bbce_core.sv
// Execution unit for bit logic, bit-test branches, calls and carry invert
// Behaviour
// - bit_or_op ORs selected bit into destination
// - bit_or_op sets Z, clears S
// - bit_or_op: opcode 07, 3 bytes, 6 cycles
// - bit_xor_op XORs selected bit into destination
// - bit_xor_op sets Z, clears S
// - Branch on clear bit adds displacement
// - Branch on set bit adds displacement
// - Bit-test branches leave flags alone
// - Second byte: address, bit, variant
// - Call pushes low then high byte
// - Pushed address follows the call
// - Three call encodings with their cycles
// - carry_invert_op flips carry only
// - carry_invert_op: opcode EF, 4 cycles
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module bbce_core
    import bbce_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Instruction issue
    input wire logic ins_valid,
    input wire logic [7:0] ins_opc,
    input wire logic [7:0] ins_b1,
    input wire logic [7:0] ins_b2,
    input wire logic [15:0] ins_pc,
    output logic ins_busy,
    output logic ins_done,
    // Register file, one-cycle read
    output logic [7:0] rf_addr,
    input wire logic [7:0] rf_rdata,
    output logic rf_we,
    output logic [7:0] rf_wdata,
    // Program memory, one-cycle read
    output logic [15:0] pm_addr,
    input wire logic [7:0] pm_rdata,
    // Stack
    input wire logic [15:0] sp_in,
    output logic [15:0] sp_out,
    output logic sp_we,
    output logic [15:0] stk_addr,
    output logic [7:0] stk_data,
    output logic stk_we,
    // Program counter and flags
    output logic [15:0] pc_out,
    output logic pc_we,
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out,
    output logic flags_we,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // One bit of OR or XOR
    function automatic logic op_bit(input logic a, input logic b, input logic x);
        op_bit = x ? (a ^ b) : (a | b);
    endfunction : op_bit

    // Working register address from a 4-bit field
    function automatic logic [7:0] wreg(input logic [3:0] r);
        wreg = {WREG_HI, r};
    endfunction : wreg

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bbce_state_e st_reg, st_next;           // Sequencer state
    logic [4:0] cyc_reg, cyc_next;          // Cycles since issue
    logic [4:0] need_reg, need_next;        // Cycles of this instruction
    logic [7:0] opc_reg, opc_next;          // Latched opcode
    logic [7:0] b1_reg, b1_next;            // Latched second byte
    logic [7:0] b2_reg, b2_next;            // Latched third byte
    logic [15:0] ret_reg, ret_next;         // Next sequential address
    logic [15:0] tgt_reg, tgt_next;         // Call target
    logic [7:0] a_reg, a_next;              // Destination operand
    logic pm_sel_reg, pm_sel_next;          // Target bytes from program memory
    logic [7:0] ctrl_reg, ctrl_next;        // Control register
    logic taken_reg, taken_next;            // Last branch taken
    logic bad_reg, bad_next;                // Unknown opcode seen, sticky
    logic [7:0] rd_reg, rd_next;            // Read data
    logic busy_reg, done_reg;
    logic [7:0] rfa_reg, rfa_next;
    logic rfw_reg, rfw_next;
    logic [7:0] rfd_reg, rfd_next;
    logic [15:0] pma_reg, pma_next;
    logic [15:0] spo_reg, spo_next;
    logic spw_reg, spw_next;
    logic [15:0] ska_reg, ska_next;
    logic [7:0] skd_reg, skd_next;
    logic skw_reg, skw_next;
    logic [15:0] pco_reg, pco_next;
    logic pcw_reg, pcw_next;
    logic [7:0] flo_reg, flo_next;
    logic flw_reg, flw_next;
    logic done_next;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire is_or = (ins_opc == OPC_BIT_OR);
    wire is_xor = (ins_opc == OPC_BIT_XOR);
    wire is_btjr = (ins_opc == OPC_BTJR);
    wire is_call = (ins_opc == OPC_CALL_DIR) || (ins_opc == OPC_CALL_PAIR) || (ins_opc == OPC_CALL_VEC);
    wire is_cinv = (ins_opc == OPC_CINV);
    wire known_w = is_or || is_xor || is_btjr || is_call || is_cinv;
    wire issue_w = (st_reg == ST_IDLE) && ins_valid && ctrl_reg[CTRL_EN];
    wire acc_w = issue_w && known_w;
    // Latched fields: address, bit number, variant bit
    wire [3:0] f_addr = b1_reg[7:4];
    wire [2:0] f_bit = b1_reg[3:1];
    wire f_sel = b1_reg[0];
    wire op_x = (opc_reg == OPC_BIT_XOR);
    wire op_bitlog = (opc_reg == OPC_BIT_OR) || op_x;
    wire op_btjr = (opc_reg == OPC_BTJR);
    // Destination and source of the bit logic
    wire [7:0] dst_addr = f_sel ? b2_reg : wreg(f_addr);
    wire [7:0] src_addr = f_sel ? wreg(f_addr) : b2_reg;
    // Result bit for both variants
    wire res0 = op_bit(a_reg[0], rf_rdata[f_bit], op_x);
    wire resb = op_bit(a_reg[f_bit], rf_rdata[0], op_x);
    wire res_w = f_sel ? resb : res0;
    // Branch condition: variant bit 0 jumps on clear, 1 on set
    wire tbit_w = rf_rdata[f_bit];
    wire take_w = (tbit_w == f_sel);
    // Signed displacement from the following address
    wire [15:0] br_tgt = ret_reg + {{8{b2_reg[7]}}, b2_reg};
    wire [7:0] mdat_w = pm_sel_reg ? pm_rdata : rf_rdata;
    wire [4:0] cyc_inc = cyc_reg + 5'h01;
    // Done is raised in the last cycle, so the next issue lands n cycles on
    wire [4:0] need_m1 = need_reg - 5'h01;
    wire [15:0] sp_m1 = sp_in - LEN_1;
    wire [15:0] sp_m2 = sp_in - LEN_2;
    wire wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
    wire wr_stat = reg_wr && (reg_addr == OFS_STAT);
    wire [7:0] stat_w = {5'h00, bad_reg, taken_reg, busy_reg};

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        cyc_next = cyc_inc;
        need_next = need_reg;
        opc_next = opc_reg;
        b1_next = b1_reg;
        b2_next = b2_reg;
        ret_next = ret_reg;
        tgt_next = tgt_reg;
        a_next = a_reg;
        pm_sel_next = pm_sel_reg;
        taken_next = taken_reg;
        rfa_next = rfa_reg;
        rfw_next = 1'b0;
        rfd_next = rfd_reg;
        pma_next = pma_reg;
        spo_next = spo_reg;
        spw_next = 1'b0;
        ska_next = ska_reg;
        skd_next = skd_reg;
        skw_next = 1'b0;
        pco_next = pco_reg;
        pcw_next = 1'b0;
        flo_next = flo_reg;
        flw_next = 1'b0;
        done_next = 1'b0;
        case (st_reg)
            // Wait for an instruction and start it
            ST_IDLE:
            begin
                cyc_next = 5'h01;
                opc_next = ins_opc;
                b1_next = ins_b1;
                b2_next = ins_b2;
                if (acc_w)
                begin
                    st_next = ST_RD1;
                    if (is_or || is_xor)
                    begin
                        need_next = is_or ? CYC_BIT_OR : CYC_BIT_XOR;
                        ret_next = ins_pc + LEN_3;
                        rfa_next = ins_b1[0] ? ins_b2 : wreg(ins_b1[7:4]);
                    end
                    else if (is_btjr)
                    begin
                        need_next = CYC_BTJR;
                        ret_next = ins_pc + LEN_3;
                        rfa_next = wreg(ins_b1[7:4]);
                    end
                    else if (ins_opc == OPC_CALL_DIR)
                    begin
                        need_next = CYC_CALL_DIR;
                        ret_next = ins_pc + LEN_3;
                        tgt_next = {ins_b1, ins_b2};
                        st_next = ST_PUSHL;
                    end
                    else if (ins_opc == OPC_CALL_PAIR)
                    begin
                        need_next = CYC_CALL_PAIR;
                        ret_next = ins_pc + LEN_2;
                        rfa_next = ins_b1;
                        pm_sel_next = 1'b0;
                    end
                    else if (ins_opc == OPC_CALL_VEC)
                    begin
                        // vector in program memory, 2 bytes
                        need_next = CYC_CALL_VEC;
                        ret_next = ins_pc + LEN_2;
                        pma_next = {8'h00, ins_b1};
                        pm_sel_next = 1'b1;
                    end
                    else
                    begin
                        // flip carry, one byte, 4 cycles
                        need_next = CYC_CINV;
                        ret_next = ins_pc + LEN_1;
                        flo_next = flags_in ^ FLG_C_MASK;
                        flw_next = 1'b1;
                        st_next = ST_WAIT;
                    end
                end
            end
            // First operand arrives
            ST_RD1:
            begin
                st_next = ST_RD2;
                if (op_bitlog)
                begin
                    a_next = rf_rdata;
                    rfa_next = src_addr;
                end
                else if (op_btjr)
                begin
                    // Flags untouched on both outcomes
                    taken_next = take_w;
                    pco_next = take_w ? br_tgt : ret_reg;
                    pcw_next = 1'b1;
                    st_next = ST_WAIT;
                end
                else
                begin
                    // Target high byte first
                    tgt_next = {mdat_w, tgt_reg[7:0]};
                    rfa_next = rfa_reg + 8'h01;
                    pma_next = pma_reg + LEN_1;
                end
            end
            // Second operand arrives
            ST_RD2:
            begin
                if (op_bitlog)
                begin
                    // Write only the chosen bit
                    rfa_next = dst_addr;
                    rfd_next = a_reg;
                    rfd_next[f_sel ? f_bit : 3'h0] = res_w;
                    rfw_next = 1'b1;
                    // Z from result, S cleared, rest kept
                    flo_next = flags_in;
                    flo_next[FLG_Z] = ~res_w;
                    flo_next[FLG_S] = 1'b0;
                    flw_next = 1'b1;
                    st_next = ST_WAIT;
                end
                else
                begin
                    tgt_next = {tgt_reg[15:8], mdat_w};
                    st_next = ST_PUSHL;
                end
            end
            // Push low byte of the return address
            ST_PUSHL:
            begin
                ska_next = sp_m1;
                skd_next = ret_reg[7:0];
                skw_next = 1'b1;
                st_next = ST_PUSHH;
            end
            // Push high byte, move stack pointer, jump
            ST_PUSHH:
            begin
                ska_next = sp_m2;
                skd_next = ret_reg[15:8];
                skw_next = 1'b1;
                spo_next = sp_m2;
                spw_next = 1'b1;
                pco_next = tgt_reg;
                pcw_next = 1'b1;
                st_next = ST_WAIT;
            end
            // Pad to the instruction's cycle count
            ST_WAIT:
            begin
                if (cyc_reg >= need_m1)
                begin
                    done_next = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            default:
            begin
                st_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    assign ctrl_next = wr_ctrl ? reg_wdata : ctrl_reg;
    // Unknown opcode sets the flag; set wins over a write-one clear
    assign bad_next = (issue_w && !known_w) || (bad_reg && !(wr_stat && reg_wdata[STAT_BAD]));
    assign rd_next = !reg_rd ? 8'h00 : (reg_addr == OFS_CTRL) ? ctrl_reg : (reg_addr == OFS_STAT) ? stat_w : 8'h00;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Sequencer and operand state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= ST_IDLE;
            cyc_reg <= 5'h00;
            need_reg <= 5'h00;
            opc_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            ret_reg <= 16'h0000;
            tgt_reg <= 16'h0000;
            a_reg <= 8'h00;
            pm_sel_reg <= 1'b0;
            taken_reg <= 1'b0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
            cyc_reg <= cyc_next;
            need_reg <= need_next;
            opc_reg <= opc_next;
            b1_reg <= b1_next;
            b2_reg <= b2_next;
            ret_reg <= ret_next;
            tgt_reg <= tgt_next;
            a_reg <= a_next;
            pm_sel_reg <= pm_sel_next;
            taken_reg <= taken_next;
        end
    end

    // Output flops toward the core
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rfa_reg <= 8'h00;
            rfw_reg <= 1'b0;
            rfd_reg <= 8'h00;
            pma_reg <= 16'h0000;
            spo_reg <= 16'h0000;
            spw_reg <= 1'b0;
            ska_reg <= 16'h0000;
            skd_reg <= 8'h00;
            skw_reg <= 1'b0;
            pco_reg <= 16'h0000;
            pcw_reg <= 1'b0;
            flo_reg <= 8'h00;
            flw_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (ce)
        begin
            rfa_reg <= rfa_next;
            rfw_reg <= rfw_next;
            rfd_reg <= rfd_next;
            pma_reg <= pma_next;
            spo_reg <= spo_next;
            spw_reg <= spw_next;
            ska_reg <= ska_next;
            skd_reg <= skd_next;
            skw_reg <= skw_next;
            pco_reg <= pco_next;
            pcw_reg <= pcw_next;
            flo_reg <= flo_next;
            flw_reg <= flw_next;
            busy_reg <= (st_next != ST_IDLE);
            done_reg <= done_next;
        end
    end

    // Register port state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RST;
            bad_reg <= 1'b0;
            rd_reg <= 8'h00;
        end
        else if (ce)
        begin
            ctrl_reg <= ctrl_next;
            bad_reg <= bad_next;
            rd_reg <= rd_next;
        end
    end

    // Outputs straight from flops
    assign ins_busy = busy_reg;
    assign ins_done = done_reg;
    assign rf_addr = rfa_reg;
    assign rf_we = rfw_reg;
    assign rf_wdata = rfd_reg;
    assign pm_addr = pma_reg;
    assign sp_out = spo_reg;
    assign sp_we = spw_reg;
    assign stk_addr = ska_reg;
    assign stk_data = skd_reg;
    assign stk_we = skw_reg;
    assign pc_out = pco_reg;
    assign pc_we = pcw_reg;
    assign flags_out = flo_reg;
    assign flags_we = flw_reg;
    assign reg_rdata = rd_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    bitop_time_a: assert property ((acc_w && is_or) |-> ##6 ins_done)
        else $error("bit_or_op did not finish in 6 cycles");
    cinv_time_a: assert property ((acc_w && is_cinv) |-> ##4 ins_done)
        else $error("carry_invert_op did not finish in 4 cycles");
    cinv_flag_a: assert property ((acc_w && is_cinv)
        |=> flags_we && (flags_out == ($past(flags_in) ^ FLG_C_MASK)))
        else $error("carry_invert_op changed more than carry");
    branch_flags_a: assert property ((busy_reg && op_btjr) |-> !flags_we)
        else $error("bit-test branch wrote flags");
    bit_zero_a: assert property ((rf_we && op_bitlog) |-> flags_we && !flags_out[FLG_S]
        && (flags_out[FLG_Z] == !rf_wdata[f_sel ? f_bit : 3'h0]))
        else $error("bit logic flags wrong");
    call_order_a: assert property ((acc_w && is_call) |-> ##[2:4] (stk_we && !sp_we) ##1 (stk_we && sp_we))
        else $error("call push order wrong");
    call_ret_a: assert property ((acc_w && ins_opc == OPC_CALL_DIR) |-> ##2 stk_we
        && stk_data == 8'($past(ins_pc, 2) + LEN_3))
        else $error("call pushed wrong return byte");
    call_time_a: assert property ((acc_w && ins_opc == OPC_CALL_PAIR) |-> ##12 ins_done)
        else $error("pair call did not finish in 12 cycles");
    branch_pc_a: assert property ((acc_w && is_btjr) |-> ##2 pc_we)
        else $error("branch did not load the program counter");

    bitop_c: cover property (acc_w && is_xor ##6 ins_done);
    taken_c: cover property (pc_we && op_btjr && taken_next);
    call_c: cover property (acc_w && ins_opc == OPC_CALL_VEC ##14 ins_done);
    cinv_c: cover property (acc_w && is_cinv);

endmodule : bbce_core

// >>> inc/bbce_pkg.sv
// Constants and types shared by the bit, branch and call execution unit
package bbce_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_BIT_OR = 8'h07; // bit_or_op
    localparam logic [7:0] OPC_BIT_XOR = 8'h27; // bit_xor_op, plain default
    localparam logic [7:0] OPC_BTJR = 8'h37;     // Bit-test branches, plain default
    localparam logic [7:0] OPC_CALL_DIR = 8'hF6; // direct_target_mode call
    localparam logic [7:0] OPC_CALL_PAIR = 8'hF4; // pair_indirect_mode call
    localparam logic [7:0] OPC_CALL_VEC = 8'hD4; // vector_indirect_mode call
    localparam logic [7:0] OPC_CINV = 8'hEF; // carry_invert_op

    // ------------------------------------------------------------
    // Cycle counts and lengths
    // ------------------------------------------------------------
    localparam logic [4:0] CYC_BIT_OR = 5'h06;
    localparam logic [4:0] CYC_BIT_XOR = 5'h06;
    localparam logic [4:0] CYC_BTJR = 5'h0A;     // Plain default
    localparam logic [4:0] CYC_CALL_DIR = 5'h0E;
    localparam logic [4:0] CYC_CALL_PAIR = 5'h0C;
    localparam logic [4:0] CYC_CALL_VEC = 5'h0E;
    localparam logic [4:0] CYC_CINV = 5'h04;
    localparam logic [15:0] LEN_1 = 16'h0001;
    localparam logic [15:0] LEN_2 = 16'h0002;
    localparam logic [15:0] LEN_3 = 16'h0003;

    // ------------------------------------------------------------
    // Flags and register file layout
    // ------------------------------------------------------------
    localparam int FLG_C = 7;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 5;
    localparam logic [7:0] FLG_C_MASK = 8'h80;
    localparam logic [3:0] WREG_HI = 4'hC;       // Working register page

    // ------------------------------------------------------------
    // Register port map
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam int CTRL_EN = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_TAKEN = 1;
    localparam int STAT_BAD = 2;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RD1 = 7'h02,
        ST_RD2 = 7'h04,
        ST_PUSHL = 7'h08,
        ST_PUSHH = 7'h10,
        ST_WAIT = 7'h20,
        ST_SPARE = 7'h40
    } bbce_state_e;

endpackage : bbce_pkg

// >>> sim/bbce_far_model.sv
// Register file and program memory seen by the execution unit
`timescale 1ns/1ps
module bbce_far_model
(
    // Clock
    input wire logic clk,
    // Register file
    input wire logic [7:0] rf_addr,
    input wire logic rf_we,
    input wire logic [7:0] rf_wdata,
    output logic [7:0] rf_rdata,
    // Program memory
    input wire logic [15:0] pm_addr,
    output logic [7:0] pm_rdata
);
    logic [7:0] rf [256]; // Register file, preset by the bench
    logic [7:0] pm [256]; // Low page of program memory
    // Reads answer the registered address within its cycle
    assign rf_rdata = rf[rf_addr];
    assign pm_rdata = pm[pm_addr[7:0]];
    // Writes land at the edge that ends the strobe cycle
    always @(posedge clk)
    begin
        if (rf_we)
            rf[rf_addr] <= rf_wdata;
    end
endmodule : bbce_far_model

// >>> sim/bit_branch_call_exec_bench.sv
// Self-checking bench for the bit, branch and call execution unit
`timescale 1ns/1ps
module bit_branch_call_exec_bench;
    import bbce_pkg::*;
    logic clk = 0, rst = 1, ce = 1, ins_valid = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] ins_opc = 0, ins_b1 = 0, ins_b2 = 0, flags_in = 0, reg_wdata = 0;
    logic [15:0] ins_pc = 0, sp_in = 0, pc, sp = 0, tg, ret;
    logic [3:0] reg_addr = 0, a;
    logic [7:0] rf_addr, rf_rdata, rf_wdata, pm_rdata, flags_out, reg_rdata, stk_data;
    logic [15:0] pm_addr, sp_out, stk_addr, pc_out, pc_seen, sp_seen;
    logic ins_busy, ins_done, rf_we, sp_we, stk_we, pc_we, flags_we, r, sel;
    logic [7:0] fl_seen, fi, d, s, e, x;
    logic [2:0] b;
    logic [23:0] stk_q[$]; // Stack writes in order
    int n_mismatch = 0, compares = 0, nfl = 0, dfl, i;
    bbce_core dut (.*);
    bbce_far_model p (.clk(clk), .rf_addr(rf_addr), .rf_we(rf_we), .rf_wdata(rf_wdata),
        .rf_rdata(rf_rdata), .pm_addr(pm_addr), .pm_rdata(pm_rdata));
    // 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Record every flags, program counter, stack pointer and stack strobe; register file writes land in the model
    always @(posedge clk)
    begin
        if (flags_we)
            nfl <= nfl + 1;
        if (flags_we)
            fl_seen <= flags_out;
        if (pc_we)
            pc_seen <= pc_out;
        if (sp_we)
            sp_seen <= sp_out;
        if (stk_we)
            stk_q.push_back({stk_addr, stk_data});
    end
    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Issue one instruction and count cycles to its done pulse
    task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input int n);
        int k;
        int base;
        base = nfl;
        pc = 16'($urandom);
        fi = 8'($urandom);
        stk_q.delete();
        @(posedge clk);
        {ins_opc, ins_b1, ins_b2, ins_pc} <= {op, b1, b2, pc};
        flags_in <= fi;
        sp_in <= sp;
        ins_valid <= 1'b1;
        @(posedge clk);
        ins_valid <= 1'b0;
        k = 1;
        while (ins_done !== 1'b1 && k < 40)
        begin
            @(posedge clk);
            #1;
            k++;
            if (k == 2)
                chk(24'(ins_busy), 24'h1);
        end
        chk(24'(k), 24'(n));
        chk(24'(ins_busy), 24'h0);
        if (k >= 40)
            final_report();
        dfl = nfl - base;
    endtask : run
    // Register port read, data stands one cycle after the strobe
    task automatic rd(input logic [3:0] ad, output logic [7:0] q);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask : rd
    // Register port write, one cycle with the strobe
    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Main sequence
    initial
    begin
        void'($urandom(32'hBA2F));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CTRL, d);
        chk(d, CTRL_RST);
        rd(4'h9, d);
        chk(d, 8'h00);
        // Bit OR and XOR in both directions
        for (i = 0; i < 16; i++)
        begin
            a = 4'($urandom);
            b = 3'($urandom);
            sel = i[1];
            x = 8'($urandom_range(0, 191));
            p.rf[x] = 8'($urandom);
            p.rf[{WREG_HI, a}] = 8'($urandom);
            d = sel ? p.rf[x] : p.rf[{WREG_HI, a}];
            s = sel ? p.rf[{WREG_HI, a}] : p.rf[x];
            r = sel ? s[0] : s[b];
            r = i[0] ? r ^ (sel ? d[b] : d[0]) : r | (sel ? d[b] : d[0]);
            e = d;
            e[sel ? b : 3'h0] = r;
            run(i[0] ? OPC_BIT_XOR : OPC_BIT_OR, {a, b, sel}, x, 6);
            chk(sel ? p.rf[x] : p.rf[{WREG_HI, a}], e);
            chk(sel ? p.rf[{WREG_HI, a}] : p.rf[x], s);
            chk({fl_seen, 8'(dfl)}, {fi[7], ~r, 1'b0, fi[4:0], 8'h01});
        end
        // Bit-test branches, taken and not taken
        for (i = 0; i < 8; i++)
        begin
            a = 4'($urandom);
            b = 3'($urandom);
            d = 8'($urandom);
            d[b] = i[1];
            p.rf[{WREG_HI, a}] = d;
            s = 8'($urandom); // Every byte lies within +127..-128
            run(OPC_BTJR, {a, b, i[0]}, s, 10);
            r = i[0] ? i[1] : !i[1];
            chk(pc_seen, pc + LEN_3 + (r ? {{8{s[7]}}, s} : 16'h0));
            chk(24'(dfl), 24'h0);
        end
        // Calls in all three encodings
        for (i = 0; i < 3; i++)
        begin
            x = 8'($urandom_range(0, 94) * 2);
            tg = 16'($urandom);
            {p.rf[x], p.rf[x + 8'h01]} = tg;
            {p.pm[x], p.pm[x + 8'h01]} = tg;
            sp = 16'($urandom_range(2, 65535));
            run(i == 0 ? OPC_CALL_DIR : i == 1 ? OPC_CALL_PAIR : OPC_CALL_VEC,
                i == 0 ? tg[15:8] : x, tg[7:0], i == 1 ? 12 : 14);
            ret = pc + (i == 0 ? LEN_3 : LEN_2);
            chk(stk_q[0], {sp - 16'h1, ret[7:0]});
            chk(stk_q[1], {sp - 16'h2, ret[15:8]});
            chk({sp_seen, 8'(dfl)}, {sp - 16'h2, 8'h00});
            chk(pc_seen, tg);
        end
        // Carry invert
        run(OPC_CINV, 8'h00, 8'h00, 4);
        chk({fl_seen, 8'(dfl)}, {fi ^ FLG_C_MASK, 8'h01});
        // Unknown opcode sets the sticky status bit, a written one clears it
        @(posedge clk);
        ins_opc <= 8'h00;
        ins_valid <= 1'b1;
        @(posedge clk);
        ins_valid <= 1'b0;
        rd(OFS_STAT, d);
        chk(d, (8'h01 << STAT_BAD) | (8'h01 << STAT_TAKEN));
        wr(OFS_STAT, 8'h01 << STAT_BAD);
        rd(OFS_STAT, d);
        chk(d, 8'h01 << STAT_TAKEN);
        final_report();
    end
endmodule : bit_branch_call_exec_bench
